//--- core/tmr_core.sv
// Eight-bit timer/counter with two compare units and waveform outputs.
//
// Summary of operation
// R01 - Count and both compare values are 8-bit registers software can access.
// R02 - BOTTOM is a count of 0x00.
// R03 - MAX is a count of 0xFF, decimal 255.
// R04 - TOP is MAX or compare value A, chosen by the wave mode.
// R05 - Count is compared with compare values A and B every cycle.
// R06 - A match sets the matching unit's compare flag, a possible interrupt.
// R07 - Three interrupt sources: overflow, match A and match B.
// R08 - All flags are readable; each is masked by its own mask bit.
// R09 - Source is prescaler or external pin, with selectable pin edge.
// R10 - With no source selected the timer neither counts nor makes events.
// R11 - Source select is bits 2 to 0 of control register B.
// R12 - In PWM modes compare values are double buffered and loaded at a set point.
// R13 - Clear-on-match mode clears the count when it matches A.
// R14 - Compare results drive PWM or frequency waves on outputs A and B.
// R15 - Timer runs while its power-off bit is zero.
// R16 - Match flag sets on next tick; cleared by writing one or on service.
// R17 - Software count write beats count or clear; works while stopped.
// R18 - External pin is synchronised and edge detected before counting.
`timescale 1ns/1ps
`default_nettype none

module tmr_core (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	// Register port
	input  wire tmr_pkg::tmr_bus_req_t bus_req,
	output var  logic [7:0]           rdata,
	// External count pin and interrupt service
	input  wire logic                 ext_count_pin,
	input  wire logic [2:0]           irq_ack,
	// Waveforms and interrupt
	output var  logic                 wave_out_a,
	output var  logic                 wave_out_b,
	output var  logic                 irq
);
	import tmr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tmr_com_t             com_a;
	tmr_com_t             com_b;
	logic [2:0]           wgm;
	tmr_clk_sel_t         clock_source_sel;
	logic [7:0]           timer_count;
	logic [7:0]           compare_value_a;
	logic [7:0]           compare_value_b;
	logic [7:0]           cmp_act_a;
	logic [7:0]           cmp_act_b;
	logic [2:0]           timer_flag_reg;
	logic [2:0]           timer_mask_reg;
	logic                 timer_power_off;
	logic [TMR_PRE_W-1:0] prescale;
	logic                 ext_s1;
	logic                 ext_s2;
	logic                 ext_s3;
	tmr_dir_t             dir;
	logic                 oc_a;
	logic                 oc_b;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_ctrl_a = bus_req.wr && bus_req.addr == TMR_OFS_CTRL_A;
	wire wr_ctrl_b = bus_req.wr && bus_req.addr == TMR_OFS_CTRL_B;
	wire wr_count  = bus_req.wr && bus_req.addr == TMR_OFS_COUNT;
	wire wr_cmp_a  = bus_req.wr && bus_req.addr == TMR_OFS_CMP_A;
	wire wr_cmp_b  = bus_req.wr && bus_req.addr == TMR_OFS_CMP_B;
	wire wr_mask   = bus_req.wr && bus_req.addr == TMR_OFS_MASK;
	wire wr_flag   = bus_req.wr && bus_req.addr == TMR_OFS_FLAG;
	wire wr_clear  = bus_req.wr && bus_req.addr == TMR_OFS_CLEAR;
	wire wr_power  = bus_req.wr && bus_req.addr == TMR_OFS_POWER;

	// ----------------------------------------------------------------
	// Mode and compare
	// ----------------------------------------------------------------
	wire is_pc   = wgm == TMR_WGM_PC_MAX || wgm == TMR_WGM_PC_CMPA;
	wire is_fast = wgm == TMR_WGM_FAST_MAX || wgm == TMR_WGM_FAST_CMPA;
	wire is_pwm  = is_pc || is_fast;
	wire top_is_a = wgm == TMR_WGM_CTC || wgm == TMR_WGM_PC_CMPA ||
		wgm == TMR_WGM_FAST_CMPA;
	// Outside PWM the buffer is the compare value itself.
	wire [7:0] eff_a = is_pwm ? cmp_act_a : compare_value_a; // R12
	wire [7:0] eff_b = is_pwm ? cmp_act_b : compare_value_b; // R12
	wire [7:0] top_val = top_is_a ? eff_a : TMR_MAX; // R04
	wire at_top    = timer_count == top_val; // R04
	wire at_bottom = timer_count == TMR_BOTTOM; // R02
	wire at_max    = timer_count == TMR_MAX; // R03
	wire match_a   = timer_count == eff_a; // R05
	wire match_b   = timer_count == eff_b; // R05

	// ----------------------------------------------------------------
	// Clock select
	// ----------------------------------------------------------------
	wire [9:0] pre_mask =
		clock_source_sel == TMR_CS_DIV8    ? TMR_PRE_MASK_DIV8 :
		clock_source_sel == TMR_CS_DIV64   ? TMR_PRE_MASK_DIV64 :
		clock_source_sel == TMR_CS_DIV256  ? TMR_PRE_MASK_DIV256 :
		clock_source_sel == TMR_CS_DIV1024 ? TMR_PRE_MASK_DIV1024 :
		TMR_PRE_MASK_DIV1;
	wire int_sel = clock_source_sel != TMR_CS_STOP &&
		clock_source_sel != TMR_CS_EXT_FALL &&
		clock_source_sel != TMR_CS_EXT_RISE; // R11
	wire ext_rise = ext_s2 && !ext_s3; // R18
	wire ext_fall = !ext_s2 && ext_s3; // R18
	wire pre_hit = (prescale & pre_mask) == pre_mask;
	wire timer_tick = !timer_power_off && ( // R15
		(int_sel && pre_hit) ||
		(clock_source_sel == TMR_CS_EXT_FALL && ext_fall) ||
		(clock_source_sel == TMR_CS_EXT_RISE && ext_rise)); // R09 R10

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic [7:0] next_count;
	tmr_dir_t   next_dir;
	always_comb begin
		next_count = timer_count;
		next_dir   = dir;
		if (timer_tick) begin
			if (is_pc) begin
				if (dir == TMR_DIR_UP && at_top) begin
					next_dir   = TMR_DIR_DOWN;
					next_count = timer_count - 8'h01;
				end else if (dir == TMR_DIR_DOWN && at_bottom) begin
					next_dir   = TMR_DIR_UP;
					next_count = timer_count + 8'h01;
				end else if (dir == TMR_DIR_UP) begin
					next_count = timer_count + 8'h01;
				end else begin
					next_count = timer_count - 8'h01;
				end
			end else if (at_top) begin
				next_count = TMR_BOTTOM; // R13
			end else begin
				next_count = timer_count + 8'h01;
			end
		end
		if (wr_count) begin
			next_count = bus_req.wdata; // R17
		end
	end

	// ----------------------------------------------------------------
	// Events and buffer load
	// ----------------------------------------------------------------
	wire down    = dir == TMR_DIR_DOWN;
	wire ev_ovf  = timer_tick && (is_pc ? (down && at_bottom) :
		is_fast ? at_top : at_max);
	wire ev_a    = timer_tick && match_a; // R06 R16
	wire ev_b    = timer_tick && match_b; // R06 R16
	wire wrap_ev = timer_tick && is_fast && at_top;
	wire upd     = timer_tick && at_top && (is_fast || !down); // R12
	wire load_act = !is_pwm || upd; // R12

	// ----------------------------------------------------------------
	// Waveform generation
	// ----------------------------------------------------------------
	function automatic logic wave_next(input logic oc, input tmr_com_t com,
		input logic ev, input logic wrap, input logic dn);
		logic set_val;
		set_val = com == TMR_COM_SET;
		wave_next = oc;
		if (com == TMR_COM_OFF) begin
			wave_next = oc;
		end else if (!is_pwm) begin
			if (ev) begin
				wave_next = com == TMR_COM_TOGGLE ? !oc : set_val;
			end
		end else if (com != TMR_COM_TOGGLE) begin
			if (is_fast && wrap) begin
				wave_next = !set_val;
			end else if (is_fast && ev) begin
				wave_next = set_val;
			end else if (is_pc && ev) begin
				wave_next = dn ? !set_val : set_val;
			end
		end
	endfunction

	wire next_oc_a = wave_next(oc_a, com_a, ev_a, wrap_ev, down); // R14
	wire next_oc_b = wave_next(oc_b, com_b, ev_b, wrap_ev, down); // R14

	// ----------------------------------------------------------------
	// Flags and interrupt
	// ----------------------------------------------------------------
	wire [2:0] flag_set = {ev_b, ev_a, ev_ovf}; // R07
	wire [2:0] flag_clr = ((wr_flag || wr_clear) ?
		bus_req.wdata[2:0] : 3'h0) | irq_ack; // R16
	// A new event in the clearing cycle wins over the clear.
	wire [2:0] next_flags = (timer_flag_reg & ~flag_clr) | flag_set;
	wire [2:0] next_mask = wr_mask ? bus_req.wdata[2:0] : timer_mask_reg;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [7:0] rd_val =
		bus_req.addr == TMR_OFS_CTRL_A ?
			{com_a, com_b, 2'h0, wgm[1:0]} :
		bus_req.addr == TMR_OFS_CTRL_B ?
			{4'h0, wgm[2], clock_source_sel} :
		bus_req.addr == TMR_OFS_COUNT ? timer_count :
		bus_req.addr == TMR_OFS_CMP_A ? compare_value_a :
		bus_req.addr == TMR_OFS_CMP_B ? compare_value_b :
		bus_req.addr == TMR_OFS_MASK  ? {5'h00, timer_mask_reg} :
		bus_req.addr == TMR_OFS_FLAG  ? {5'h00, timer_flag_reg} :
		bus_req.addr == TMR_OFS_POWER ? {7'h00, timer_power_off} :
		8'h00;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			com_a            <= TMR_COM_OFF;
			com_b            <= TMR_COM_OFF;
			wgm              <= TMR_WGM_NORMAL;
			clock_source_sel <= TMR_CS_STOP;
			timer_power_off  <= TMR_RST_POWER_OFF;
		end else begin
			if (wr_ctrl_a) begin
				com_a    <= tmr_com_t'(bus_req.wdata[TMR_CTRLA_COMA_LSB +: 2]);
				com_b    <= tmr_com_t'(bus_req.wdata[TMR_CTRLA_COMB_LSB +: 2]);
				wgm[1:0] <= bus_req.wdata[1:0];
			end
			if (wr_ctrl_b) begin
				wgm[2]           <= bus_req.wdata[TMR_CTRLB_WGM2];
				clock_source_sel <= tmr_clk_sel_t'(bus_req.wdata[2:0]); // R11
			end
			if (wr_power) begin
				timer_power_off <= bus_req.wdata[0]; // R15
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			timer_count     <= TMR_RST_BYTE;
			dir             <= TMR_DIR_UP;
			compare_value_a <= TMR_RST_BYTE;
			compare_value_b <= TMR_RST_BYTE;
			cmp_act_a       <= TMR_RST_BYTE;
			cmp_act_b       <= TMR_RST_BYTE;
		end else begin
			timer_count <= next_count; // R01 R17
			dir         <= next_dir;
			if (wr_cmp_a) begin
				compare_value_a <= bus_req.wdata; // R01
			end
			if (wr_cmp_b) begin
				compare_value_b <= bus_req.wdata; // R01
			end
			if (load_act) begin
				cmp_act_a <= compare_value_a; // R12
				cmp_act_b <= compare_value_b; // R12
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prescale <= '0;
			ext_s1   <= 1'b0;
			ext_s2   <= 1'b0;
			ext_s3   <= 1'b0;
		end else begin
			prescale <= timer_power_off ? '0 : prescale + 1'b1;
			ext_s1   <= ext_count_pin; // R18
			ext_s2   <= ext_s1;
			ext_s3   <= ext_s2;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			timer_flag_reg <= TMR_RST_FLAGS;
			timer_mask_reg <= TMR_RST_FLAGS;
			irq            <= 1'b0;
			oc_a           <= 1'b0;
			oc_b           <= 1'b0;
			wave_out_a     <= 1'b0;
			wave_out_b     <= 1'b0;
			rdata          <= TMR_RST_BYTE;
		end else begin
			timer_flag_reg <= next_flags; // R06 R07 R16
			timer_mask_reg <= next_mask;
			irq            <= |(next_flags & next_mask); // R08
			oc_a           <= next_oc_a;
			oc_b           <= next_oc_b;
			wave_out_a     <= next_oc_a && com_a != TMR_COM_OFF; // R14
			wave_out_b     <= next_oc_b && com_b != TMR_COM_OFF; // R14
			rdata          <= bus_req.rd ? rd_val : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_count_write_wins: assert property (wr_count |=> // R17
		timer_count == $past(bus_req.wdata))
		else $error("Count write did not take effect.");
	a_stopped_holds: assert property ( // R10
		(clock_source_sel == TMR_CS_STOP && !wr_count) |=>
		(timer_count == $past(timer_count) && timer_flag_reg[0] ==
		($past(timer_flag_reg[0]) && !$past(flag_clr[0]))))
		else $error("Stopped timer changed its count or overflow flag.");
	a_power_off_holds: assert property ( // R15
		(timer_power_off && !wr_count) |=> $stable(timer_count))
		else $error("Powered-off timer counted.");
	a_match_a_flag: assert property ( // R06
		(timer_tick && timer_count == eff_a) |=>
		timer_flag_reg[TMR_FLAG_MATCH_A])
		else $error("Match A did not set its flag.");
	a_match_b_flag: assert property ( // R06
		(timer_tick && timer_count == eff_b) |=>
		timer_flag_reg[TMR_FLAG_MATCH_B])
		else $error("Match B did not set its flag.");
	a_normal_wrap: assert property ( // R03
		(timer_tick && wgm == TMR_WGM_NORMAL && timer_count == 8'hFF &&
		!wr_count) |=> (timer_count == 8'h00 && timer_flag_reg[0]))
		else $error("Normal mode did not wrap from 0xFF with overflow.");
	a_ctc_clear: assert property ( // R13
		(timer_tick && wgm == TMR_WGM_CTC &&
		timer_count == compare_value_a && !wr_count) |=>
		timer_count == 8'h00)
		else $error("Clear-on-match mode did not clear the count.");
	a_irq_level: assert property ( // R08
		((timer_flag_reg & timer_mask_reg) != 3'h0) == irq)
		else $error("Interrupt does not follow enabled flags.");
	a_flag_clear: assert property ( // R16
		(wr_clear && bus_req.wdata[1] && !ev_a) |=>
		!timer_flag_reg[TMR_FLAG_MATCH_A])
		else $error("Writing one did not clear match flag A.");
	a_buffer_hold: assert property ( // R12
		(is_pwm && wr_cmp_a && !upd) |=>
		(cmp_act_a == $past(cmp_act_a)))
		else $error("Compare buffer loaded outside its point.");
	a_ext_rise_tick: assert property ( // R18
		(clock_source_sel == TMR_CS_EXT_RISE && !timer_power_off &&
		wgm == TMR_WGM_NORMAL && !wr_count && !ext_s3) ##1
		(ext_s3 && !wr_count && $stable(clock_source_sel)) |->
		timer_count == $past(timer_count) + 8'h01)
		else $error("Synchronised rising edge did not advance count.");
	a_pc_bottom_turn: assert property ( // R02
		(timer_tick && is_pc && down && at_bottom && !wr_count) |=>
		(timer_flag_reg[TMR_FLAG_OVF] && dir == TMR_DIR_UP))
		else $error("Phase-correct count did not turn at bottom.");
	a_buffer_load: assert property ( // R12
		upd |=> (cmp_act_a == $past(compare_value_a) &&
		cmp_act_b == $past(compare_value_b)))
		else $error("Compare buffer did not load at top.");
	a_fast_wrap_set: assert property ( // R14
		(timer_tick && is_fast && at_top &&
		com_a == TMR_COM_CLEAR) |=> wave_out_a)
		else $error("Fast wave A was not set at wrap.");
	a_read_idle: assert property ( // R01
		!bus_req.rd |=> rdata == 8'h00)
		else $error("Read data stood without a read strobe.");

	c_overflow: cover property (ev_ovf && timer_mask_reg[0]);
	c_pc_turn: cover property (is_pc && timer_tick && at_top);
	c_ext_tick: cover property (timer_tick && !int_sel);
	c_fast_wave: cover property (is_fast && wave_out_a ##1 !wave_out_a);

endmodule

`default_nettype wire

//--- include/tmr_pkg.sv
// Package with the register map, field layout and types of the 8-bit timer.
package tmr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] TMR_OFS_CTRL_A  = 4'h0;
	localparam logic [3:0] TMR_OFS_CTRL_B  = 4'h1;
	localparam logic [3:0] TMR_OFS_COUNT   = 4'h2;
	localparam logic [3:0] TMR_OFS_CMP_A   = 4'h3;
	localparam logic [3:0] TMR_OFS_CMP_B   = 4'h4;
	localparam logic [3:0] TMR_OFS_MASK    = 4'h5;
	localparam logic [3:0] TMR_OFS_FLAG    = 4'h6;
	localparam logic [3:0] TMR_OFS_CLEAR   = 4'h7;
	localparam logic [3:0] TMR_OFS_POWER   = 4'h8;

	// ----------------------------------------------------------------
	// Fields, values after reset and count limits
	// ----------------------------------------------------------------
	localparam int unsigned TMR_CTRLA_COMA_LSB = 6;
	localparam int unsigned TMR_CTRLA_COMB_LSB = 4;
	localparam int unsigned TMR_CTRLB_WGM2     = 3;
	localparam int unsigned TMR_FLAG_OVF       = 0;
	localparam int unsigned TMR_FLAG_MATCH_A   = 1;
	localparam int unsigned TMR_FLAG_MATCH_B   = 2;
	localparam int unsigned TMR_PRE_W          = 10;
	localparam logic [7:0]  TMR_BOTTOM         = 8'h00;
	localparam logic [7:0]  TMR_MAX            = 8'hFF;
	localparam logic [7:0]  TMR_RST_BYTE       = 8'h00;
	localparam logic [2:0]  TMR_RST_FLAGS      = 3'h0;
	localparam logic        TMR_RST_POWER_OFF  = 1'b0;
	localparam logic [9:0]  TMR_PRE_MASK_DIV1    = 10'h000;
	localparam logic [9:0]  TMR_PRE_MASK_DIV8    = 10'h007;
	localparam logic [9:0]  TMR_PRE_MASK_DIV64   = 10'h03F;
	localparam logic [9:0]  TMR_PRE_MASK_DIV256  = 10'h0FF;
	localparam logic [9:0]  TMR_PRE_MASK_DIV1024 = 10'h3FF;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TMR_CS_STOP    = 3'h0,
		TMR_CS_DIV1    = 3'h1,
		TMR_CS_DIV8    = 3'h2,
		TMR_CS_DIV64   = 3'h3,
		TMR_CS_DIV256  = 3'h4,
		TMR_CS_DIV1024 = 3'h5,
		TMR_CS_EXT_FALL = 3'h6,
		TMR_CS_EXT_RISE = 3'h7
	} tmr_clk_sel_t;

	typedef enum logic [2:0] {
		TMR_WGM_NORMAL    = 3'h0,
		TMR_WGM_PC_MAX    = 3'h1,
		TMR_WGM_CTC       = 3'h2,
		TMR_WGM_FAST_MAX  = 3'h3,
		TMR_WGM_PC_CMPA   = 3'h5,
		TMR_WGM_FAST_CMPA = 3'h7
	} tmr_wgm_t;

	typedef enum logic [1:0] {
		TMR_COM_OFF    = 2'h0,
		TMR_COM_TOGGLE = 2'h1,
		TMR_COM_CLEAR  = 2'h2,
		TMR_COM_SET    = 2'h3
	} tmr_com_t;

	typedef enum logic {
		TMR_DIR_UP   = 1'b0,
		TMR_DIR_DOWN = 1'b1
	} tmr_dir_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmr_bus_req_t;

endpackage

//--- test/tmr_core_tb.sv
// Self-checking testbench of the eight-bit timer core.
`timescale 1ns/1ps
`default_nettype none

module tmr_core_tb;
	import tmr_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         ref_clk;
	logic         rstn;
	tmr_bus_req_t bus_req;
	logic [7:0]   rdata;
	logic         ext_count_pin;
	logic [2:0]   irq_ack;
	logic         wave_out_a;
	logic         wave_out_b;
	logic         irq;
	logic [31:0]  seed;
	int           errors;
	int           n_checks;

	tmr_core tmr_core_inst (
		.ref_clk       (ref_clk),
		.rstn          (rstn),
		.bus_req       (bus_req),
		.rdata         (rdata),
		.ext_count_pin (ext_count_pin),
		.irq_ack       (irq_ack),
		.wave_out_a    (wave_out_a),
		.wave_out_b    (wave_out_b),
		.irq           (irq)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd8();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h", $time, msg, got);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %b", $time, msg, got);
		end
	endtask

	task automatic chk_rng(input logic [9:0] got, input int lo, input int hi,
		input string msg);
		n_checks++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: %s got %0d", $time, msg, got);
		end
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		@(negedge ref_clk);
		d = rdata;
	endtask

	task automatic run(input logic [7:0] sel, input int n);
		bus_wr(TMR_OFS_CTRL_B, sel);
		repeat (n) @(posedge ref_clk);
		bus_wr(TMR_OFS_CTRL_B, 8'h00);
	endtask

	task automatic run_case(input logic [7:0] c0, input logic [7:0] a,
		input logic [7:0] b, input logic [2:0] fl);
		logic [7:0] d;
		bus_wr(TMR_OFS_COUNT, c0);
		bus_wr(TMR_OFS_CMP_A, a);
		bus_wr(TMR_OFS_CMP_B, b);
		bus_wr(TMR_OFS_FLAG, 8'h07);
		run(8'h01, 30);
		bus_rd(TMR_OFS_COUNT, d);
		chk_rng({2'b00, d - c0}, 28, 34, "ticks at full rate");
		bus_rd(TMR_OFS_FLAG, d);
		chk8(d, {5'h00, fl}, "flags after run");
	endtask

	task automatic settle_irq(input logic exp, input string msg);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk1(irq, exp, msg);
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		final_report();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] c0;
		logic       prev;
		int         k;
		int         cnt_a;
		int         cnt_b;
		seed = 32'h242E5597;
		errors = 0;
		n_checks = 0;
		rstn = 1'b0;
		bus_req = '0;
		ext_count_pin = 1'b0;
		irq_ack = 3'h0;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		// Every register and an unmapped offset read zero after reset.
		for (k = 0; k < 9; k++) begin
			bus_rd(4'(k), d);
			chk8(d, TMR_RST_BYTE, "reset value");
		end
		bus_rd(4'hF, d);
		chk8(d, 8'h00, "unmapped offset");
		chk1(irq, 1'b0, "irq after reset");
		// Stopped timer keeps what software writes.
		for (k = 0; k < 3; k++) begin
			c0 = rnd8();
			bus_wr(TMR_OFS_COUNT + 4'(k), c0);
			repeat (10) @(posedge ref_clk);
			bus_rd(TMR_OFS_COUNT + 4'(k), d);
			chk8(d, c0, "stopped readback");
		end
		// Matches and overflow set only the flags that were passed.
		c0 = rnd8() & 8'h7F;
		run_case(c0, c0 + 8'h0A, c0 + 8'h64, 3'b010);
		run_case(8'hF0, 8'h80, 8'h05, 3'b101);
		// Mask, service acknowledge and clear register.
		bus_wr(TMR_OFS_MASK, 8'h01);
		settle_irq(1'b1, "irq on overflow");
		@(posedge ref_clk);
		irq_ack <= 3'b001;
		@(posedge ref_clk);
		irq_ack <= 3'b000;
		settle_irq(1'b0, "irq after service");
		bus_rd(TMR_OFS_FLAG, d);
		chk8(d, 8'h04, "flags after service");
		bus_wr(TMR_OFS_MASK, 8'h04);
		settle_irq(1'b1, "irq on match b");
		bus_rd(TMR_OFS_CLEAR, d);
		chk8(d, 8'h00, "clear register reads zero");
		bus_wr(TMR_OFS_CLEAR, 8'h04);
		settle_irq(1'b0, "irq after clear");
		// Powered off, a selected source still makes no ticks.
		bus_wr(TMR_OFS_POWER, 8'h01);
		bus_wr(TMR_OFS_COUNT, 8'h33);
		run(8'h01, 40);
		bus_rd(TMR_OFS_COUNT, d);
		chk8(d, 8'h33, "count while powered off");
		bus_rd(TMR_OFS_FLAG, d);
		chk8(d, 8'h00, "flags while powered off");
		bus_wr(TMR_OFS_POWER, 8'h00);
		// Clear-on-match with toggling output A.
		bus_wr(TMR_OFS_COUNT, 8'h00);
		bus_wr(TMR_OFS_CMP_A, 8'h05);
		bus_wr(TMR_OFS_CTRL_A, 8'h42);
		bus_wr(TMR_OFS_CTRL_B, 8'h01);
		cnt_a = 0;
		@(negedge ref_clk);
		prev = wave_out_a;
		repeat (50) begin
			@(negedge ref_clk);
			if (wave_out_a !== prev) cnt_a++;
			prev = wave_out_a;
		end
		bus_wr(TMR_OFS_CTRL_B, 8'h00);
		chk_rng(10'(cnt_a), 7, 9, "toggles on match");
		bus_rd(TMR_OFS_COUNT, d);
		chk_rng({2'b00, d}, 0, 5, "count wraps at compare a");
		bus_rd(TMR_OFS_FLAG, d);
		chk8(d, 8'h06, "flags in clear-on-match");
		// Fast PWM: A clears on match, B inverted.
		bus_wr(TMR_OFS_CTRL_A, 8'hB3);
		bus_wr(TMR_OFS_CMP_A, 8'h40);
		bus_wr(TMR_OFS_CMP_B, 8'h40);
		run(8'h01, 20);
		// Start at the wrap so both periods see the loaded buffer.
		bus_wr(TMR_OFS_COUNT, 8'hFF);
		bus_wr(TMR_OFS_CTRL_B, 8'h01);
		cnt_a = 0;
		cnt_b = 0;
		repeat (512) begin
			@(negedge ref_clk);
			if (wave_out_a === 1'b1) cnt_a++;
			if (wave_out_b === 1'b1) cnt_b++;
		end
		bus_wr(TMR_OFS_CTRL_B, 8'h00);
		chk_rng(10'(cnt_a), 126, 134, "pwm duty a");
		chk_rng(10'(cnt_b), 378, 386, "pwm duty b");
		// External pin on both edges.
		bus_wr(TMR_OFS_CTRL_A, 8'h00);
		for (k = 7; k >= 6; k--) begin
			bus_wr(TMR_OFS_COUNT, 8'h00);
			bus_wr(TMR_OFS_CTRL_B, 8'(k));
			repeat (5) begin
				repeat (4) @(posedge ref_clk);
				ext_count_pin <= 1'b1;
				repeat (4) @(posedge ref_clk);
				ext_count_pin <= 1'b0;
			end
			repeat (6) @(posedge ref_clk);
			bus_wr(TMR_OFS_CTRL_B, 8'h00);
			bus_rd(TMR_OFS_COUNT, d);
			chk8(d, 8'h05, "external edges counted");
		end
		// Phase-correct: A is high from the down match to the up match.
		bus_wr(TMR_OFS_CTRL_A, 8'h81);
		bus_wr(TMR_OFS_COUNT, 8'h00);
		bus_wr(TMR_OFS_CTRL_B, 8'h01);
		repeat (100) @(negedge ref_clk);
		cnt_a = 0;
		repeat (510) begin
			@(negedge ref_clk);
			if (wave_out_a === 1'b1) cnt_a++;
		end
		bus_wr(TMR_OFS_CTRL_B, 8'h00);
		chk_rng(10'(cnt_a), 126, 130, "phase-correct duty a");
		final_report();
	end
endmodule

`default_nettype wire
